// ### hdl/ccoi_pkg.sv
// Shared constants for the compare-output and interrupt block
package ccoi_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CCOI_CLK_NS       = 8;        // 125 MHz clock
  localparam int CCOI_TB_FINE_NS   = 125;      // Period unit, fine
  localparam int CCOI_TB_COARSE_NS = 1000;     // Period unit, coarse
  localparam int CCOI_MS_NS        = 1000000;  // One millisecond
  localparam int CCOI_ACC_W        = 20;       // Tick accumulator width

  // ****************************************************************
  // Register byte offsets
  // ****************************************************************
  localparam logic [5:0] CCOI_OFS_CTRL    = 6'h00;
  localparam logic [5:0] CCOI_OFS_CMPVAL  = 6'h04;
  localparam logic [5:0] CCOI_OFS_HYST    = 6'h08;
  localparam logic [5:0] CCOI_OFS_PULSE   = 6'h0c;
  localparam logic [5:0] CCOI_OFS_STATUS  = 6'h10;
  localparam logic [5:0] CCOI_OFS_DATA    = 6'h14;
  localparam logic [5:0] CCOI_OFS_IRQSTAT = 6'h18;
  localparam logic [5:0] CCOI_OFS_IRQEN   = 6'h1c;
  localparam logic [5:0] CCOI_OFS_IRQCLR  = 6'h20;

  // ****************************************************************
  // Control field positions
  // ****************************************************************
  localparam int CCOI_CTRL_W      = 7;
  localparam int CCOI_C_MODE_LO   = 0;  // Two bits, output behaviour
  localparam int CCOI_C_HWGATE    = 2;  // Hardware gate in use
  localparam int CCOI_C_FREQ1K    = 3;  // Max counting frequency 1 kHz
  localparam int CCOI_C_DATAPER   = 4;  // Data word shows period
  localparam int CCOI_C_TB1US     = 5;  // Period unit 1 us
  localparam int CCOI_C_SWGATE    = 6;  // Software gate open

  // ****************************************************************
  // Interrupt bits
  // ****************************************************************
  localparam int CCOI_IRQ_N      = 6;
  localparam int CCOI_I_GOPEN    = 0;
  localparam int CCOI_I_GCLOSE   = 1;
  localparam int CCOI_I_CMP      = 2;
  localparam int CCOI_I_OVF      = 3;
  localparam int CCOI_I_UNF      = 4;
  localparam int CCOI_I_EDGE     = 5;

  // Output behaviour
  typedef enum logic [1:0] {
    CCOI_MODE_NONE  = 2'h0,
    CCOI_MODE_GE    = 2'h1,
    CCOI_MODE_LE    = 2'h2,
    CCOI_MODE_PULSE = 2'h3
  } ccoi_mode_t;

  // Pulse generator states, one-hot
  typedef enum logic [1:0] {
    CCOI_ST_IDLE  = 2'h1,
    CCOI_ST_PULSE = 2'h2
  } ccoi_pulse_t;

endpackage

// ### hdl/ccoi_sync.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/100ps
module ccoi_sync (
  input  wire logic clock,  // System clock
  input  wire logic rst_n,  // Async reset, active low
  input  wire logic din,    // Asynchronous level
  output logic      dout    // Synchronised level
);
  typedef struct packed {
    logic s1;
    logic s2;
  } ccoi_sync_t;

  ccoi_sync_t st_reg;
  ccoi_sync_t st_next;

  // First flop feeds only the second
  always_comb begin
    st_next    = st_reg;
    st_next.s1 = din;
    st_next.s2 = st_reg.s1;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign dout = st_reg.s2;
endmodule // ccoi_sync

// ### hdl/ccoi_tick.sv
// Fractional tick generator for a period given in nanoseconds
`timescale 1ns/100ps
module ccoi_tick
  import ccoi_pkg::*;
(
  input  wire logic                  clock,    // System clock
  input  wire logic                  rst_n,    // Async reset, active low
  input  wire logic                  restart,  // Realign phase to now
  input  wire logic [CCOI_ACC_W-1:0] periodNs, // Tick period in ns
  output logic                       tick      // One-cycle pulse
);
  localparam logic [CCOI_ACC_W-1:0] STEP = CCOI_ACC_W'(CCOI_CLK_NS);

  typedef struct packed {
    logic [CCOI_ACC_W-1:0] acc;
    logic                  tick;
  } ccoi_tick_t;

  ccoi_tick_t st_reg;
  ccoi_tick_t st_next;
  logic [CCOI_ACC_W:0] sum;

  // Remainder carried over so a 125 ns unit stays exact on average
  always_comb begin
    st_next      = st_reg;
    sum          = {1'b0, st_reg.acc} + {1'b0, STEP};
    st_next.tick = 1'b0;
    if (restart) begin
      st_next.acc = '0;
    end else if (sum >= {1'b0, periodNs}) begin
      st_next.acc  = CCOI_ACC_W'(sum - {1'b0, periodNs});
      st_next.tick = 1'b1;
    end else begin
      st_next.acc = sum[CCOI_ACC_W-1:0];
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign tick = st_reg.tick;
endmodule // ccoi_tick

// ### hdl/ccoi_top.sv
// Compare output, period measurement and interrupt block
//
// Behaviour
// R1: Output and compare flag follow the mode: none, >=, <= or pulse.
// R2: Pulse length is 0 to 510 ms in even steps, zero after reset.
// R3: Data word shows period only at 1 kHz max frequency, else count.
// R4: Period is counted in 125 ns units or 1 us units.
// R5: No period is measured above 1 kHz max frequency.
// R6: Hardware gate opening with software gate open raises an event.
// R7: Hardware gate closing with software gate open raises an event.
// R8: Reaching the compare condition raises an event.
// R9: Passing the upper counting limit raises an event.
// R10: Dropping below the lower counting limit raises an event.
// R11: Counting-edge event exists only at 1 kHz max frequency.
// R12: Hysteresis of 0 to 255 counts, values 0 and 1 switch it off.
// R13: With hardware gate chosen both gates open counting, else software.
// R14: Each source has its own enable, all cleared by reset.
// R15: Pulse starts when count becomes equal and lasts the set time.
//
// The register addresses and the Avalon-MM register port are this design's own decisions.
`timescale 1ns/100ps
module ccoi_top
  import ccoi_pkg::*;
#(
  parameter int MS_NS = CCOI_MS_NS  // Millisecond length, shorten in sim
) (
  input  wire logic        clock,           // 125 MHz clock
  input  wire logic        rst_n,           // Async reset, active low
  input  wire logic [5:0]  avs_address,     // Byte address
  input  wire logic        avs_read,        // Read request
  input  wire logic        avs_write,       // Write request
  input  wire logic [31:0] avs_writedata,   // Write data
  input  wire logic [3:0]  avs_byteenable,  // Write byte lanes
  output logic [31:0]      avs_readdata,    // Read data
  output logic             avs_waitrequest, // Stall, low on answer
  input  wire logic [31:0] countValue,      // Signed count from core
  input  wire logic        countEdge,       // Counting edge pulse
  input  wire logic        overflowEvt,     // Upper limit passed pulse
  input  wire logic        underflowEvt,    // Lower limit passed pulse
  input  wire logic        hwGatePin,       // Hardware gate pin
  output logic             gateOpen,        // Counting enabled to core
  output logic             digOut,          // Digital output
  output logic             compareStatusFlag, // Comparator status
  output logic             irq              // Level interrupt
);
  typedef struct packed {
    logic [CCOI_CTRL_W-1:0] ctrl;
    logic [31:0]            cmpVal;
    logic [7:0]             hyst;
    logic [7:0]             pulseHalf;  // Pulse length in 2 ms steps
    logic [CCOI_IRQ_N-1:0]  irqStat;
    logic [CCOI_IRQ_N-1:0]  irqEn;
    logic                   waitReq;
    logic [31:0]            rdata;
    logic                   cmpFlag;
    logic                   digOut;
    logic                   gateOpen;
    logic                   hwGatePrev;
    ccoi_pulse_t            pulseSt;
    logic [8:0]             msCnt;
    logic [31:0]            periodCnt;
    logic [31:0]            period;
    logic                   irq;
  } ccoi_top_state_t;

  ccoi_top_state_t st_reg;
  ccoi_top_state_t st_next;

  // ****************************************************************
  // Pin synchroniser and time bases
  // ****************************************************************
  logic hwGateS;
  logic tbTick;
  logic msTick;
  logic pulseStart;
  logic [CCOI_ACC_W-1:0] tbNs;

  ccoi_sync u_gate_sync (
    .clock (clock),
    .rst_n (rst_n),
    .din   (hwGatePin),
    .dout  (hwGateS)
  );

  // Period unit chosen by software
  assign tbNs = st_reg.ctrl[CCOI_C_TB1US] ? CCOI_ACC_W'(CCOI_TB_COARSE_NS)
                                          : CCOI_ACC_W'(CCOI_TB_FINE_NS);

  // Phase realigned on each edge so the first unit is full length
  ccoi_tick u_tb_tick (
    .clock    (clock),
    .rst_n    (rst_n),
    .restart  (countEdge),
    .periodNs (tbNs),
    .tick     (tbTick)
  );

  ccoi_tick u_ms_tick (
    .clock    (clock),
    .rst_n    (rst_n),
    .restart  (pulseStart),
    .periodNs (CCOI_ACC_W'(MS_NS)),
    .tick     (msTick)
  );

  // ****************************************************************
  // Control decode
  // ****************************************************************
  ccoi_mode_t mode;
  logic swGate;
  logic hwSel;
  logic freq1k;
  logic eqNow;
  logic [33:0] cntX;
  logic [33:0] lowThr;
  logic [33:0] highThr;
  logic [7:0] hystEff;
  logic [CCOI_IRQ_N-1:0] ev;
  logic [31:0] wmask;
  logic access;

  assign mode   = ccoi_mode_t'(st_reg.ctrl[CCOI_C_MODE_LO +: 2]);
  assign swGate = st_reg.ctrl[CCOI_C_SWGATE];
  assign hwSel  = st_reg.ctrl[CCOI_C_HWGATE];
  assign freq1k = st_reg.ctrl[CCOI_C_FREQ1K];
  assign eqNow  = (countValue == st_reg.cmpVal);
  assign access = avs_read | avs_write;

  // Wide signed thresholds so cmp +/- hysteresis cannot wrap
  assign hystEff = (st_reg.hyst > 8'h01) ? st_reg.hyst : 8'h00; // [R12]
  assign cntX    = {{2{countValue[31]}}, countValue};
  assign lowThr  = {{2{st_reg.cmpVal[31]}}, st_reg.cmpVal}
                   - {26'h0, hystEff};
  assign highThr = {{2{st_reg.cmpVal[31]}}, st_reg.cmpVal}
                   + {26'h0, hystEff};

  assign pulseStart = (st_reg.pulseSt == CCOI_ST_IDLE)
                      && (mode == CCOI_MODE_PULSE) && eqNow
                      && !st_reg.cmpFlag
                      && (st_reg.pulseHalf != 8'h00); // [R15]

  assign wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                  {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb begin
    st_next = st_reg;

    // Gate towards the counter core
    st_next.gateOpen   = swGate & (~hwSel | hwGateS); // [R13]
    st_next.hwGatePrev = hwGateS;

    // Compare flag per output behaviour
    case (mode)
      CCOI_MODE_GE: begin
        if (!st_reg.cmpFlag) begin
          st_next.cmpFlag = $signed(cntX) >= $signed(lowThr + {26'h0,
                                                      hystEff}); // [R1]
        end else begin
          st_next.cmpFlag = !($signed(cntX) < $signed(lowThr)); // [R12]
        end
      end
      CCOI_MODE_LE: begin
        if (!st_reg.cmpFlag) begin
          st_next.cmpFlag = $signed(cntX) <= $signed(highThr - {26'h0,
                                                      hystEff}); // [R1]
        end else begin
          st_next.cmpFlag = !($signed(cntX) > $signed(highThr)); // [R12]
        end
      end
      CCOI_MODE_PULSE: st_next.cmpFlag = eqNow; // [R1]
      default:         st_next.cmpFlag = 1'b0;  // [R1]
    endcase

    // Output: level modes copy the flag, pulse mode times a pulse
    case (st_reg.pulseSt)
      CCOI_ST_IDLE: begin
        st_next.digOut = (mode == CCOI_MODE_GE || mode == CCOI_MODE_LE)
                         ? st_next.cmpFlag : 1'b0; // [R1]
        if (pulseStart) begin
          st_next.pulseSt = CCOI_ST_PULSE; // [R15]
          st_next.msCnt   = 9'h000;
          st_next.digOut  = 1'b1;
        end
      end
      CCOI_ST_PULSE: begin
        if (msTick) begin
          st_next.msCnt = st_reg.msCnt + 9'h001;
        end
        // Ends after pulseHalf*2 ms, or at once if mode is left
        if (mode != CCOI_MODE_PULSE || (msTick &&
            (st_reg.msCnt + 9'h001) >= {st_reg.pulseHalf, 1'b0})) begin
          st_next.pulseSt = CCOI_ST_IDLE; // [R2] [R15]
          st_next.digOut  = 1'b0;
        end
      end
      default: begin
        st_next.pulseSt = CCOI_ST_IDLE;
        st_next.digOut  = 1'b0;
      end
    endcase

    // Period between counting edges, only at 1 kHz
    if (!freq1k) begin
      st_next.periodCnt = 32'h0; // [R5]
      st_next.period    = 32'h0;
    end else if (countEdge) begin
      st_next.period    = st_reg.periodCnt; // [R4]
      st_next.periodCnt = 32'h0;
    end else if (tbTick && st_reg.periodCnt != 32'hffffffff) begin
      st_next.periodCnt = st_reg.periodCnt + 32'h1; // [R4]
    end

    // Events
    ev = '0;
    ev[CCOI_I_GOPEN]  = hwSel & swGate & hwGateS
                        & ~st_reg.hwGatePrev; // [R6]
    ev[CCOI_I_GCLOSE] = hwSel & swGate & ~hwGateS
                        & st_reg.hwGatePrev; // [R7]
    ev[CCOI_I_CMP]    = st_next.cmpFlag & ~st_reg.cmpFlag; // [R8]
    ev[CCOI_I_OVF]    = overflowEvt;  // [R9]
    ev[CCOI_I_UNF]    = underflowEvt; // [R10]
    ev[CCOI_I_EDGE]   = countEdge & freq1k; // [R11]

    // Bus: one wait state, then the answer edge
    st_next.waitReq = !(access && st_reg.waitReq);
    if (access && st_reg.waitReq) begin
      case (avs_address)
        CCOI_OFS_CTRL:    st_next.rdata = 32'(st_reg.ctrl);
        CCOI_OFS_CMPVAL:  st_next.rdata = st_reg.cmpVal;
        CCOI_OFS_HYST:    st_next.rdata = 32'(st_reg.hyst);
        CCOI_OFS_PULSE:   st_next.rdata = 32'({st_reg.pulseHalf, 1'b0});
        CCOI_OFS_STATUS:  st_next.rdata = 32'({st_reg.pulseSt ==
                            CCOI_ST_PULSE, st_reg.gateOpen, hwGateS,
                            st_reg.digOut, st_reg.cmpFlag});
        CCOI_OFS_DATA:    st_next.rdata = (freq1k &&
                            st_reg.ctrl[CCOI_C_DATAPER])
                            ? st_reg.period : countValue; // [R3]
        CCOI_OFS_IRQSTAT: st_next.rdata = 32'(st_reg.irqStat);
        CCOI_OFS_IRQEN:   st_next.rdata = 32'(st_reg.irqEn);
        default:          st_next.rdata = 32'h0;
      endcase
    end

    // Writes land on the edge where waitrequest is seen low
    if (avs_write && !st_reg.waitReq) begin
      case (avs_address)
        CCOI_OFS_CTRL: begin
          st_next.ctrl = CCOI_CTRL_W'((32'(st_reg.ctrl) & ~wmask)
                         | (avs_writedata & wmask));
          // Period selection is not selectable above 1 kHz
          if (!st_next.ctrl[CCOI_C_FREQ1K]) begin
            st_next.ctrl[CCOI_C_DATAPER] = 1'b0; // [R3]
          end
        end
        CCOI_OFS_CMPVAL: begin
          st_next.cmpVal = (st_reg.cmpVal & ~wmask)
                           | (avs_writedata & wmask);
        end
        CCOI_OFS_HYST: begin
          if (avs_byteenable[0]) st_next.hyst = avs_writedata[7:0];
        end
        CCOI_OFS_PULSE: begin
          // Only even milliseconds are kept
          if (avs_byteenable[0] && avs_byteenable[1]) begin
            st_next.pulseHalf = avs_writedata[8:1]; // [R2]
          end
        end
        CCOI_OFS_IRQEN: begin
          if (avs_byteenable[0]) begin
            st_next.irqEn = avs_writedata[CCOI_IRQ_N-1:0]; // [R14]
          end
        end
        CCOI_OFS_IRQCLR: begin
          if (avs_byteenable[0]) begin
            st_next.irqStat = st_reg.irqStat
                              & ~avs_writedata[CCOI_IRQ_N-1:0];
          end
        end
        default: ;
      endcase
    end

    // Edge bit is never enabled above 1 kHz
    if (!freq1k) begin
      st_next.irqEn[CCOI_I_EDGE] = 1'b0; // [R11]
    end

    // Set wins over a clear in the same cycle
    st_next.irqStat = st_next.irqStat | ev;
    st_next.irq     = |(st_next.irqStat & st_next.irqEn); // [R14]
  end

  // Single state register
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_reg         <= '0;
      st_reg.waitReq <= 1'b1;
      st_reg.pulseSt <= CCOI_ST_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  assign avs_readdata      = st_reg.rdata;
  assign avs_waitrequest   = st_reg.waitReq;
  assign gateOpen          = st_reg.gateOpen;
  assign digOut            = st_reg.digOut;
  assign compareStatusFlag = st_reg.cmpFlag;
  assign irq               = st_reg.irq;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  sequence gateRiseS;
    hwSel && swGate && hwGateS && !st_reg.hwGatePrev;
  endsequence
  sequence pulseArmS;
    pulseStart;
  endsequence

  gate_sw_only_a: assert property (@(posedge clock) disable iff (!rst_n)
    (swGate && !hwSel) |=> gateOpen) // [R13]
    else $error("gate not open with software gate only");
  gate_open_irq_a: assert property (@(posedge clock) disable iff (!rst_n)
    gateRiseS |=> st_reg.irqStat[CCOI_I_GOPEN]) // [R6]
    else $error("gate opening event lost");
  gate_close_irq_a: assert property (@(posedge clock)
    disable iff (!rst_n)
    (hwSel && swGate && !hwGateS && st_reg.hwGatePrev)
    |=> st_reg.irqStat[CCOI_I_GCLOSE]) // [R7]
    else $error("gate closing event lost");
  cmp_irq_a: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(compareStatusFlag) |-> st_reg.irqStat[CCOI_I_CMP]) // [R8]
    else $error("compare event lost");
  ovf_irq_a: assert property (@(posedge clock) disable iff (!rst_n)
    overflowEvt |=> st_reg.irqStat[CCOI_I_OVF]) // [R9]
    else $error("overflow event lost");
  unf_irq_a: assert property (@(posedge clock) disable iff (!rst_n)
    underflowEvt |=> st_reg.irqStat[CCOI_I_UNF]) // [R10]
    else $error("underflow event lost");
  edge_1k_a: assert property (@(posedge clock) disable iff (!rst_n)
    !freq1k |=> !st_reg.irqEn[CCOI_I_EDGE]) // [R11]
    else $error("edge interrupt enabled above 1 kHz");
  no_period_a: assert property (@(posedge clock) disable iff (!rst_n)
    !freq1k |=> (st_reg.periodCnt == 32'h0) && (st_reg.period == 32'h0))
    // [R5]
    else $error("period measured above 1 kHz");
  irq_gated_a: assert property (@(posedge clock) disable iff (!rst_n)
    irq |-> |(st_reg.irqStat & st_reg.irqEn)) // [R14]
    else $error("interrupt without enabled source");
  ge_flag_a: assert property (@(posedge clock) disable iff (!rst_n)
    (mode == CCOI_MODE_GE && $signed(countValue) >= $signed(st_reg.cmpVal))
    |=> compareStatusFlag ##0 digOut) // [R1]
    else $error("at-or-above output not set");
  hyst_hold_a: assert property (@(posedge clock) disable iff (!rst_n)
    (mode == CCOI_MODE_GE && compareStatusFlag && st_reg.hyst > 8'h01
     && $signed(cntX) >= $signed(lowThr)) |=> compareStatusFlag) // [R12]
    else $error("hysteresis did not hold output");
  pulse_start_a: assert property (@(posedge clock) disable iff (!rst_n)
    pulseArmS |=> digOut [*2]) // [R15]
    else $error("pulse did not start on equality");
  data_sel_a: assert property (@(posedge clock) disable iff (!rst_n)
    !freq1k |=> !st_reg.ctrl[CCOI_C_DATAPER]) // [R3]
    else $error("period data selected above 1 kHz");

endmodule // ccoi_top

// ### tb/ccoi_src.sv
// Counting source model standing in for the counter core and gate pin
`timescale 1ns/100ps
module ccoi_src (
  input  wire logic        clock,        // System clock
  input  wire logic        rst_n,        // Reset, active low
  input  wire logic        doLoad,       // Load the count
  input  wire logic [31:0] loadVal,      // Value to load
  input  wire logic        doEdge,       // One counting edge
  input  wire logic        doOvf,        // Upper limit passed
  input  wire logic        doUnf,        // Lower limit passed
  input  wire logic        gateLvl,      // Wanted gate level
  output logic [31:0]      countValue,   // Count to the block
  output logic             countEdge,    // Edge pulse
  output logic             overflowEvt,  // Overflow pulse
  output logic             underflowEvt, // Underflow pulse
  output logic             hwGatePin     // Gate pin level
);
  // Everything moves on the clock, as a real core would, never mid-cycle
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      countValue   <= 32'h0;
      countEdge    <= 1'b0;
      overflowEvt  <= 1'b0;
      underflowEvt <= 1'b0;
      hwGatePin    <= 1'b0;
    end else begin
      countValue   <= doLoad ? loadVal : countValue + 32'(doEdge);
      countEdge    <= doEdge;
      overflowEvt  <= doOvf;
      underflowEvt <= doUnf;
      hwGatePin    <= gateLvl;
    end
  end
endmodule // ccoi_src

// ### tb/tb.sv
// Self-checking bench for the compare output and interrupt block
`timescale 1ns/100ps
module tb;
  import ccoi_pkg::*;
  localparam int MS = 800; // One millisecond shrunk to 100 cycles
  logic clock = 1'b0, rst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
  logic [5:0]  avs_address = 6'h0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, countValue;
  logic [31:0] loadVal = 32'h0, seed = 32'h3b, q, k, c;
  logic avs_waitrequest, countEdge, overflowEvt, underflowEvt, hwGatePin;
  logic gateOpen, digOut, compareStatusFlag, irq, doLoad = 1'b0;
  logic doEdge = 1'b0, doOvf = 1'b0, doUnf = 1'b0, gateLvl = 1'b0;
  logic [1:0]  m;
  int hv[5] = '{10, 7, 6, 9, 10};
  logic he[5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
  int n_mismatch = 0, tests_run = 0;

  // 125 MHz clock
  always #4 clock = ~clock;

  ccoi_top #(.MS_NS(MS)) u_ccoi_top (.clock, .rst_n, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_byteenable(4'hf),
    .avs_readdata, .avs_waitrequest, .countValue, .countEdge,
    .overflowEvt, .underflowEvt, .hwGatePin, .gateOpen, .digOut,
    .compareStatusFlag, .irq);
  ccoi_src u_ccoi_src (.clock, .rst_n, .doLoad, .loadVal, .doEdge,
    .doOvf, .doUnf, .gateLvl, .countValue, .countEdge, .overflowEvt,
    .underflowEvt, .hwGatePin);

  // Seeded xorshift keeps random runs repeatable
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  // Flag level with hysteresis off
  function automatic logic expFlag(input logic [1:0] md,
                                   input logic [31:0] cv, kv);
    if (md == CCOI_MODE_GE) return $signed(cv) >= $signed(kv);
    return md == CCOI_MODE_LE && $signed(cv) <= $signed(kv);
  endfunction

  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask

  // One bus cycle; request held until waitrequest is seen low
  task automatic bus(input logic w, input logic [5:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    avs_address   <= a;
    avs_write     <= w;
    avs_read      <= !w;
    avs_writedata <= d;
    do begin
      @(posedge clock);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 40);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    @(posedge clock);
    if (n >= 40) begin
      n_mismatch++;
      close_out();
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rdck(input logic [5:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    check(q, e);
  endtask

  // Load a count and let the flag settle
  task automatic setCnt(input logic [31:0] v);
    doLoad  <= 1'b1;
    loadVal <= v;
    cyc(1);
    doLoad <= 1'b0;
    cyc(3);
  endtask

  // Pulse {underflow, overflow, edge} for one cycle
  task automatic evt(input logic [2:0] e);
    {doUnf, doOvf, doEdge} <= e;
    cyc(1);
    {doUnf, doOvf, doEdge} <= 3'h0;
    cyc(2);
  endtask

  // Main sequence
  initial begin
    cyc(16);
    rst_n <= 1'b1;
    cyc(2);
    rdck(CCOI_OFS_CTRL, 32'h0);
    rdck(CCOI_OFS_PULSE, 32'h0);
    rdck(CCOI_OFS_IRQEN, 32'h0);
    rdck(6'h24, 32'h0);
    for (int i = 0; i < 12; i++) begin
      seed = xs(seed);
      k = seed;
      m = seed[0] ? CCOI_MODE_GE : CCOI_MODE_LE;
      c = k + {{29{seed[7]}}, seed[7:5]};
      wr(CCOI_OFS_CMPVAL, k);
      wr(CCOI_OFS_CTRL, {30'h0, m});
      setCnt(c);
      check(compareStatusFlag, expFlag(m, c, k));
      check(digOut, expFlag(m, c, k));
    end
    // Hysteresis of 3 holds the flag down to cmp-3
    wr(CCOI_OFS_CMPVAL, 32'ha);
    wr(CCOI_OFS_HYST, 32'h3);
    wr(CCOI_OFS_CTRL, 32'h1);
    foreach (hv[i]) begin
      setCnt(32'(hv[i]));
      check(compareStatusFlag, he[i]);
    end
    wr(CCOI_OFS_HYST, 32'h0);
    wr(CCOI_OFS_PULSE, 32'h5);
    rdck(CCOI_OFS_PULSE, 32'h4);
    wr(CCOI_OFS_CTRL, 32'h3);
    wr(CCOI_OFS_CMPVAL, 32'h64);
    setCnt(32'h63);
    wr(CCOI_OFS_IRQCLR, 32'h3f);
    check(digOut, 1'b0);
    setCnt(32'h64);
    check(digOut, 1'b1);
    cyc(350);
    check(digOut, 1'b1);
    cyc(80);
    check(digOut, 1'b0);
    rdck(CCOI_OFS_IRQSTAT, 32'h4);
    check(irq, 1'b0);
    wr(CCOI_OFS_IRQEN, 32'h4);
    check(irq, 1'b1);
    wr(CCOI_OFS_IRQCLR, 32'h4);
    check(irq, 1'b0);
    wr(CCOI_OFS_CTRL, 32'h0);
    setCnt(32'h64);
    check(compareStatusFlag, 1'b0);
    wr(CCOI_OFS_IRQEN, 32'h18);
    evt(3'b010);
    check(irq, 1'b1);
    rdck(CCOI_OFS_IRQSTAT, 32'h8);
    wr(CCOI_OFS_IRQCLR, 32'h8);
    evt(3'b100);
    rdck(CCOI_OFS_IRQSTAT, 32'h10);
    wr(CCOI_OFS_IRQCLR, 32'h10);
    check(irq, 1'b0);
    wr(CCOI_OFS_IRQEN, 32'h3f);
    rdck(CCOI_OFS_IRQEN, 32'h1f);
    evt(3'b001);
    rdck(CCOI_OFS_IRQSTAT, 32'h0);
    wr(CCOI_OFS_CTRL, 32'h8);
    wr(CCOI_OFS_IRQEN, 32'h3f);
    evt(3'b001);
    rdck(CCOI_OFS_IRQSTAT, 32'h20);
    check(irq, 1'b1);
    // Edges 250 cycles apart: 2000 ns, within one unit of slack
    for (int j = 0; j < 2; j++) begin
      wr(CCOI_OFS_CTRL, j ? 32'h38 : 32'h18);
      evt(3'b001);
      cyc(247);
      evt(3'b001);
      bus(1'b0, CCOI_OFS_DATA, 32'h0);
      check(q >= (j ? 1 : 15) && q <= (j ? 3 : 17), 1'b1);
    end
    wr(CCOI_OFS_CTRL, 32'h10);
    rdck(CCOI_OFS_CTRL, 32'h0);
    setCnt(32'h1234);
    rdck(CCOI_OFS_DATA, 32'h1234);
    wr(CCOI_OFS_IRQCLR, 32'h3f);
    wr(CCOI_OFS_IRQEN, 32'h3);
    wr(CCOI_OFS_CTRL, 32'h44);
    check(gateOpen, 1'b0);
    gateLvl <= 1'b1;
    cyc(6);
    check(gateOpen, 1'b1);
    rdck(CCOI_OFS_IRQSTAT, 32'h1);
    gateLvl <= 1'b0;
    cyc(6);
    rdck(CCOI_OFS_IRQSTAT, 32'h3);
    check(irq, 1'b1);
    wr(CCOI_OFS_IRQCLR, 32'h3);
    wr(CCOI_OFS_CTRL, 32'h4);
    gateLvl <= 1'b1;
    cyc(6);
    check(gateOpen, 1'b0);
    gateLvl <= 1'b0;
    cyc(6);
    rdck(CCOI_OFS_IRQSTAT, 32'h0);
    wr(CCOI_OFS_CTRL, 32'h40);
    // Gate output is registered one edge after the control write lands
    cyc(1);
    check(gateOpen, 1'b1);
    rdck(CCOI_OFS_STATUS, 32'h8);
    close_out();
  end
endmodule // tb
